// *** hdl/fault_zone_pkg.sv ***
/*
 * Constants for the fault-zone propagation and power-good mapping block:
 * channel and zone geometry, setting widths, masks, reset values, timing.
 * Assumes nothing of its surroundings; shared by every design file.
 */
package fault_zone_pkg;

    localparam int unsigned NUM_CHANNELS    = 8;
    localparam int unsigned CHANS_PER_ZONE  = 4;
    localparam int unsigned NUM_ZONES       = 2;
    localparam int unsigned PAGE_W          = 3;
    localparam int unsigned PROP_W          = 8;
    localparam int unsigned PG_EN_W         = 16;
    localparam int unsigned RESP_W          = 8;

    // fields of the settings
    localparam int unsigned PROP_EN_BIT     = 0;
    localparam int unsigned PG_WDOG_BIT     = 8;
    localparam logic [PROP_W-1:0]  PROP_WR_MASK  = 8'h01;
    localparam logic [PG_EN_W-1:0] PG_EN_WR_MASK = 16'h01FF;
    localparam logic [RESP_W-1:0]  RESP_WR_MASK  = 8'h0F;

    // reset values
    localparam logic [PROP_W-1:0]  PROP_RESET    = 8'h00;
    localparam logic [PG_EN_W-1:0] PG_EN_RESET   = 16'h0000;
    localparam logic [RESP_W-1:0]  RESP_RESET    = 8'h00;

    // setting selectors on the command port
    typedef enum logic [2:0] {
        SEL_PROP_A,
        SEL_PROP_B,
        SEL_PG_EN,
        SEL_RESP_Z0A,
        SEL_RESP_Z0B,
        SEL_RESP_Z1A,
        SEL_RESP_Z1B,
        SEL_NONE
    } setting_sel_t;

    // fault pin deglitch before shutdown
    localparam int unsigned CLOCK_HZ        = 50_000_000;
    localparam int unsigned FAULT_HOLD_NS   = 10_000;
    localparam int unsigned FAULT_HOLD_CYC  =
        (FAULT_HOLD_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned HOLD_CNT_W      = 10;

    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_WAIT,
        PIN_TRIPPED
    } pin_state_t;

    // zone of a channel number
    function automatic logic zone_of(input logic [PAGE_W-1:0] ch);
        return ch[PAGE_W-1];
    endfunction : zone_of

endpackage : fault_zone_pkg

// *** hdl/fault_pin_watch.sv ***
/*
 * Watches one wired fault pin and reports it tripped once it has stayed
 * low for the hold time; the trip ends as soon as the pin releases.
 * Assumes the pin input is already synchronous to CLOCK_I.
 */
`timescale 1ns/100ps
module fault_pin_watch
    import fault_zone_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // pin level and result
    input  wire logic pin_low_i,
    output logic      tripped_o
);

    pin_state_t            state;
    pin_state_t            next_state;
    logic [HOLD_CNT_W-1:0] count;
    logic [HOLD_CNT_W-1:0] next_count;

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            PIN_IDLE: begin
                next_count = '0;
                if (pin_low_i) begin
                    next_state = PIN_WAIT;
                    next_count = HOLD_CNT_W'(1);
                end
            end
            PIN_WAIT: begin
                if (!pin_low_i) begin
                    next_state = PIN_IDLE;
                end else if (count >= HOLD_CNT_W'(FAULT_HOLD_CYC)) begin
                    next_state = PIN_TRIPPED;
                end else begin
                    next_count = count + HOLD_CNT_W'(1);
                end
            end
            PIN_TRIPPED: begin
                if (!pin_low_i) begin
                    next_state = PIN_IDLE;
                end
            end
            default: next_state = PIN_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= PIN_IDLE;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    assign tripped_o = (state == PIN_TRIPPED);

endmodule : fault_pin_watch

// *** hdl/setting_store.sv ***
/*
 * Per-channel storage of the two propagate settings, one enable bit per
 * channel each; only the enable bit of the write data is kept.
 * Assumes one write at most per cycle from the parent.
 */
`timescale 1ns/100ps
module setting_store
    import fault_zone_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // write port
    input  wire logic                    wr_prop_a_i,
    input  wire logic                    wr_prop_b_i,
    input  wire logic [PAGE_W-1:0]       page_i,
    input  wire logic [PROP_W-1:0]       wdata_i,
    // stored enable bits, one per channel
    output logic      [NUM_CHANNELS-1:0] prop_a_o,
    output logic      [NUM_CHANNELS-1:0] prop_b_o
);

    logic [NUM_CHANNELS-1:0] next_prop_a;
    logic [NUM_CHANNELS-1:0] next_prop_b;

    always_comb begin
        next_prop_a = prop_a_o;
        next_prop_b = prop_b_o;
        if (wr_prop_a_i) begin
            next_prop_a[page_i] = wdata_i[PROP_EN_BIT];
        end
        if (wr_prop_b_i) begin
            next_prop_b[page_i] = wdata_i[PROP_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prop_a_o <= '0;
            prop_b_o <= '0;
        end else begin
            prop_a_o <= next_prop_a;
            prop_b_o <= next_prop_b;
        end
    end

endmodule : setting_store

// *** hdl/fault_zone_pwrgd.sv ***
/*
 * Fault-zone propagation and power-good mapping for eight channels.
 * Drives the four open-drain zone fault pins from faulted-off channels,
 * watches the same pins to request channel shutdown, and combines
 * enabled power-good sources into the power-good pin.
 * Assumes settings arrive as decoded command writes/reads with a page,
 * and that channel status and watchdog inputs are synchronous.
 */
// Behaviour
// - pages zero to three propagate only to the two zone 0 pins
// - pages four to seven propagate only to the two zone 1 pins
// - zone 0 first setting bit 0 sends fault to zone 0 pin a
// - zone 1 first setting bit 0 sends fault to zone 1 pin a
// - zone 0 second setting bit 0 sends fault to zone 0 pin b
// - zone 1 second setting bit 0 sends fault to zone 1 pin b
// - propagate bits seven to one ignored on write, read zero
// - response zero: channel keeps running when its zone pin low
// - enabled channel power-good status is ANDed into power-good pin
// - disabled channel has no influence on power-good pin
// - enable bit eight ANDs watchdog not-expired into power-good
// - enable bit eight zero: watchdog ignored for power-good
// - power-good enable bits fifteen to nine read zero
// - odd channel in high-res mode never counts toward power-good
// - response one: shut down after pin low 10us, restart on release
`timescale 1ns/100ps
module fault_zone_pwrgd
    import fault_zone_pkg::*;
(
    // clock and reset
    input  wire logic                          CLOCK_I,
    input  wire logic                          RST_I,
    // settings command port
    input  wire logic                          CMD_WRITE_I,
    input  wire logic                          CMD_READ_I,
    input  wire fault_zone_pkg::setting_sel_t  CMD_SEL_I,
    input  wire logic [fault_zone_pkg::PAGE_W-1:0]  CMD_PAGE_I,
    input  wire logic [fault_zone_pkg::PG_EN_W-1:0] CMD_WDATA_I,
    output logic      [fault_zone_pkg::PG_EN_W-1:0] CMD_RDATA_O,
    output logic                               CMD_RVALID_O,
    // channel status
    input  wire logic [fault_zone_pkg::NUM_CHANNELS-1:0] CHAN_FAULTED_OFF_I,
    input  wire logic [fault_zone_pkg::NUM_CHANNELS-1:0] CHAN_PWRGD_I,
    input  wire logic [fault_zone_pkg::NUM_CHANNELS-1:0] CHAN_HIRES_I,
    input  wire logic                          WDOG_NOT_EXPIRED_I,
    // shutdown request to channel sequencers, clears on pin release
    output logic [fault_zone_pkg::NUM_CHANNELS-1:0] CHAN_SHUTDOWN_O,
    // zone fault pins, open drain
    input  wire logic                          ZONE0_FAULT_PIN_A_I,
    output logic                               ZONE0_FAULT_PIN_A_O,
    output logic                               ZONE0_FAULT_PIN_A_OE_O,
    input  wire logic                          ZONE0_FAULT_PIN_B_I,
    output logic                               ZONE0_FAULT_PIN_B_O,
    output logic                               ZONE0_FAULT_PIN_B_OE_O,
    input  wire logic                          ZONE1_FAULT_PIN_A_I,
    output logic                               ZONE1_FAULT_PIN_A_O,
    output logic                               ZONE1_FAULT_PIN_A_OE_O,
    input  wire logic                          ZONE1_FAULT_PIN_B_I,
    output logic                               ZONE1_FAULT_PIN_B_O,
    output logic                               ZONE1_FAULT_PIN_B_OE_O,
    // power-good pin, active high level
    output logic                               PWRGD_O
);

    import fault_zone_pkg::*;

    localparam int unsigned NUM_PINS = NUM_ZONES * 2;

    logic [NUM_CHANNELS-1:0] propagate_to_pin_a;
    logic [NUM_CHANNELS-1:0] propagate_to_pin_b;
    logic [PG_EN_W-1:0]      power_good_source_enable;
    logic [PG_EN_W-1:0]      next_pg_en;
    logic [RESP_W-1:0]       fault_pin_response [NUM_PINS];
    logic [RESP_W-1:0]       next_resp [NUM_PINS];
    logic [PG_EN_W-1:0]      rdata;
    logic [PG_EN_W-1:0]      next_rdata;
    logic                    rvalid;
    logic                    next_rvalid;
    logic [NUM_PINS-1:0]     drive_low;
    logic [NUM_PINS-1:0]     next_drive_low;
    logic [NUM_CHANNELS-1:0] shutdown;
    logic [NUM_CHANNELS-1:0] next_shutdown;
    logic                    pwrgd;
    logic                    next_pwrgd;
    logic [NUM_PINS-1:0]     pin_low;
    logic [NUM_PINS-1:0]     pin_tripped;
    logic                    wr_prop_a;
    logic                    wr_prop_b;

    // pin order: zone0 a, zone0 b, zone1 a, zone1 b
    assign pin_low = {~ZONE1_FAULT_PIN_B_I, ~ZONE1_FAULT_PIN_A_I,
                      ~ZONE0_FAULT_PIN_B_I, ~ZONE0_FAULT_PIN_A_I};

    assign wr_prop_a = CMD_WRITE_I && (CMD_SEL_I == SEL_PROP_A);
    assign wr_prop_b = CMD_WRITE_I && (CMD_SEL_I == SEL_PROP_B);

    setting_store u_store (
        .clk_i    (CLOCK_I),
        .rst_i    (RST_I),
        .wr_prop_a_i (wr_prop_a),
        .wr_prop_b_i (wr_prop_b),
        .page_i   (CMD_PAGE_I),
        .wdata_i  (CMD_WDATA_I[PROP_W-1:0]),
        .prop_a_o (propagate_to_pin_a),
        .prop_b_o (propagate_to_pin_b)
    );

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_watch
            fault_pin_watch u_watch (
                .clk_i     (CLOCK_I),
                .rst_i     (RST_I),
                .pin_low_i (pin_low[gp]),
                .tripped_o (pin_tripped[gp])
            );
        end
    endgenerate

    // settings and read-back
    always_comb begin
        next_pg_en  = power_good_source_enable;
        next_resp   = fault_pin_response;
        next_rvalid = CMD_READ_I;
        next_rdata  = rdata;
        if (CMD_WRITE_I) begin
            case (CMD_SEL_I)
                SEL_PG_EN:    next_pg_en = CMD_WDATA_I & PG_EN_WR_MASK;
                SEL_RESP_Z0A: next_resp[0] =
                    CMD_WDATA_I[RESP_W-1:0] & RESP_WR_MASK;
                SEL_RESP_Z0B: next_resp[1] =
                    CMD_WDATA_I[RESP_W-1:0] & RESP_WR_MASK;
                SEL_RESP_Z1A: next_resp[2] =
                    CMD_WDATA_I[RESP_W-1:0] & RESP_WR_MASK;
                SEL_RESP_Z1B: next_resp[3] =
                    CMD_WDATA_I[RESP_W-1:0] & RESP_WR_MASK;
                default: ;
            endcase
        end
        if (CMD_READ_I) begin
            case (CMD_SEL_I)
                SEL_PROP_A: next_rdata = PG_EN_W'(
                    propagate_to_pin_a[CMD_PAGE_I]);
                SEL_PROP_B: next_rdata = PG_EN_W'(
                    propagate_to_pin_b[CMD_PAGE_I]);
                SEL_PG_EN:  next_rdata =
                    power_good_source_enable & PG_EN_WR_MASK;
                SEL_RESP_Z0A: next_rdata = PG_EN_W'(fault_pin_response[0]);
                SEL_RESP_Z0B: next_rdata = PG_EN_W'(fault_pin_response[1]);
                SEL_RESP_Z1A: next_rdata = PG_EN_W'(fault_pin_response[2]);
                SEL_RESP_Z1B: next_rdata = PG_EN_W'(fault_pin_response[3]);
                default:    next_rdata = '0;
            endcase
        end
    end

    // fault propagation, shutdown and power-good
    always_comb begin
        logic       z;
        logic [1:0] base;
        z              = 1'b0;
        base           = 2'h0;
        next_drive_low = '0;
        next_shutdown  = '0;
        next_pwrgd     = 1'b1;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            // zone picks the pin pair
            z    = zone_of(PAGE_W'(c));
            base = {z, 1'b0};
            if (CHAN_FAULTED_OFF_I[c]) begin
                if (propagate_to_pin_a[c]) begin
                    next_drive_low[base] = 1'b1;
                end
                if (propagate_to_pin_b[c]) begin
                    next_drive_low[base + 2'h1] = 1'b1;
                end
            end
            // a clear response bit leaves the channel running
            if ((fault_pin_response[base][c % CHANS_PER_ZONE]
                    && pin_tripped[base])
                || (fault_pin_response[base + 2'd1][c % CHANS_PER_ZONE]
                    && pin_tripped[base + 2'd1])) begin
                next_shutdown[c] = 1'b1;
            end
            if (power_good_source_enable[c]
                && !((c % 2 == 1) && CHAN_HIRES_I[c])) begin
                next_pwrgd = next_pwrgd & CHAN_PWRGD_I[c];
            end
        end
        if (power_good_source_enable[PG_WDOG_BIT]) begin
            next_pwrgd = next_pwrgd & WDOG_NOT_EXPIRED_I;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            power_good_source_enable <= PG_EN_RESET;
            for (int p = 0; p < NUM_PINS; p++) begin
                fault_pin_response[p] <= RESP_RESET;
            end
            rdata     <= '0;
            rvalid    <= 1'b0;
            drive_low <= '0;
            shutdown  <= '0;
            pwrgd     <= 1'b0;
        end else begin
            power_good_source_enable <= next_pg_en;
            fault_pin_response       <= next_resp;
            rdata     <= next_rdata;
            rvalid    <= next_rvalid;
            drive_low <= next_drive_low;
            shutdown  <= next_shutdown;
            pwrgd     <= next_pwrgd;
        end
    end

    // open drain: output always low, enable only when pulling
    assign ZONE0_FAULT_PIN_A_O    = 1'b0;
    assign ZONE0_FAULT_PIN_B_O    = 1'b0;
    assign ZONE1_FAULT_PIN_A_O    = 1'b0;
    assign ZONE1_FAULT_PIN_B_O    = 1'b0;
    assign ZONE0_FAULT_PIN_A_OE_O = drive_low[0];
    assign ZONE0_FAULT_PIN_B_OE_O = drive_low[1];
    assign ZONE1_FAULT_PIN_A_OE_O = drive_low[2];
    assign ZONE1_FAULT_PIN_B_OE_O = drive_low[3];

    assign CHAN_SHUTDOWN_O = shutdown;
    assign PWRGD_O         = pwrgd;
    assign CMD_RDATA_O     = rdata;
    assign CMD_RVALID_O    = rvalid;

endmodule : fault_zone_pwrgd

// *** tb/fault_zone_pwrgd_asserts.sv ***
/* checker for fault_zone_pwrgd: port-level timing of pins and reads.
   assumes one clock domain; bound to the top module at the foot */
`timescale 1ns/100ps
module fault_zone_pwrgd_asserts
    import fault_zone_pkg::*;
(
    // clock and reset
    input wire logic         CLOCK_I,
    input wire logic         RST_I,
    // command port
    input wire logic         CMD_READ_I,
    input wire setting_sel_t CMD_SEL_I,
    input wire logic [15:0]  CMD_RDATA_O,
    input wire logic         CMD_RVALID_O,
    // channel status
    input wire logic [7:0]   CHAN_FAULTED_OFF_I,
    input wire logic [7:0]   CHAN_PWRGD_I,
    input wire logic         WDOG_NOT_EXPIRED_I,
    input wire logic [7:0]   CHAN_SHUTDOWN_O,
    // pins
    input wire logic         ZONE0_FAULT_PIN_A_I,
    input wire logic         ZONE0_FAULT_PIN_B_I,
    input wire logic         ZONE0_FAULT_PIN_A_O,
    input wire logic         ZONE0_FAULT_PIN_B_O,
    input wire logic         ZONE1_FAULT_PIN_A_O,
    input wire logic         ZONE1_FAULT_PIN_B_O,
    input wire logic         ZONE0_FAULT_PIN_A_OE_O,
    input wire logic         ZONE0_FAULT_PIN_B_OE_O,
    input wire logic         ZONE1_FAULT_PIN_A_OE_O,
    input wire logic         ZONE1_FAULT_PIN_B_OE_O,
    input wire logic         PWRGD_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    // consecutive low cycles of the zone 0 pins, saturating
    logic [9:0] low_a;
    logic [9:0] low_b;
    logic [1:0] up;
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            low_a <= 10'h000;
            low_b <= 10'h000;
            up    <= 2'h0;
        end else begin
            low_a <= ZONE0_FAULT_PIN_A_I ? 10'h000 : low_a + 10'(~&low_a);
            low_b <= ZONE0_FAULT_PIN_B_I ? 10'h000 : low_b + 10'(~&low_b);
            up    <= up + 2'(~&up);
        end
    end

    sequence s_read;
        CMD_READ_I;
    endsequence
    sequence s_answer;
        ##1 CMD_RVALID_O;
    endsequence

    property p_rvalid;
        s_read |-> s_answer;
    endproperty
    property p_no_rvalid;
        !CMD_READ_I |=> !CMD_RVALID_O;
    endproperty
    property p_prop_rsv;
        CMD_READ_I && (CMD_SEL_I == SEL_PROP_A || CMD_SEL_I == SEL_PROP_B)
            |=> CMD_RDATA_O[15:1] == 15'h0000;
    endproperty
    property p_pg_rsv;
        CMD_READ_I && CMD_SEL_I == SEL_PG_EN |=> CMD_RDATA_O[15:9] == 7'h00;
    endproperty
    property p_z0a;
        !(|CHAN_FAULTED_OFF_I[3:0]) |=> !ZONE0_FAULT_PIN_A_OE_O;
    endproperty
    property p_z0b;
        !(|CHAN_FAULTED_OFF_I[3:0]) |=> !ZONE0_FAULT_PIN_B_OE_O;
    endproperty
    property p_z1a;
        !(|CHAN_FAULTED_OFF_I[7:4]) |=> !ZONE1_FAULT_PIN_A_OE_O;
    endproperty
    property p_z1b;
        !(|CHAN_FAULTED_OFF_I[7:4]) |=> !ZONE1_FAULT_PIN_B_OE_O;
    endproperty
    property p_od;
        !(ZONE0_FAULT_PIN_A_O | ZONE0_FAULT_PIN_B_O |
          ZONE1_FAULT_PIN_A_O | ZONE1_FAULT_PIN_B_O);
    endproperty
    property p_pg;
        up == 2'h3 && &CHAN_PWRGD_I && WDOG_NOT_EXPIRED_I |=> PWRGD_O;
    endproperty
    property p_sd;
        $rose(|CHAN_SHUTDOWN_O[3:0])
            |-> low_a >= FAULT_HOLD_CYC || low_b >= FAULT_HOLD_CYC;
    endproperty
    property p_sd_rel;
        (ZONE0_FAULT_PIN_A_I && ZONE0_FAULT_PIN_B_I) [*4]
            |-> CHAN_SHUTDOWN_O[3:0] == 4'h0;
    endproperty

    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray rvalid");
    a_prop_rsv: assert property (p_prop_rsv)
        else $error("prop reserved bits set");
    a_pg_rsv: assert property (p_pg_rsv) else $error("pg rsv");
    a_z0a: assert property (p_z0a) else $error("z0a driven");
    a_z0b: assert property (p_z0b) else $error("z0b driven");
    a_z1a: assert property (p_z1a) else $error("z1a driven");
    a_z1b: assert property (p_z1b) else $error("z1b driven");
    a_od: assert property (p_od) else $error("pin drives high");
    a_pg: assert property (p_pg) else $error("pwrgd low");
    a_sd: assert property (p_sd) else $error("early shutdown");
    a_sd_rel: assert property (p_sd_rel) else $error("stuck");
endmodule : fault_zone_pwrgd_asserts

bind fault_zone_pwrgd fault_zone_pwrgd_asserts i_fault_zone_pwrgd_asserts (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CMD_READ_I(CMD_READ_I),
    .CMD_SEL_I(CMD_SEL_I), .CMD_RDATA_O(CMD_RDATA_O),
    .CMD_RVALID_O(CMD_RVALID_O), .CHAN_FAULTED_OFF_I(CHAN_FAULTED_OFF_I),
    .CHAN_PWRGD_I(CHAN_PWRGD_I), .WDOG_NOT_EXPIRED_I(WDOG_NOT_EXPIRED_I),
    .CHAN_SHUTDOWN_O(CHAN_SHUTDOWN_O),
    .ZONE0_FAULT_PIN_A_I(ZONE0_FAULT_PIN_A_I),
    .ZONE0_FAULT_PIN_B_I(ZONE0_FAULT_PIN_B_I),
    .ZONE0_FAULT_PIN_A_O(ZONE0_FAULT_PIN_A_O),
    .ZONE0_FAULT_PIN_B_O(ZONE0_FAULT_PIN_B_O),
    .ZONE1_FAULT_PIN_A_O(ZONE1_FAULT_PIN_A_O),
    .ZONE1_FAULT_PIN_B_O(ZONE1_FAULT_PIN_B_O),
    .ZONE0_FAULT_PIN_A_OE_O(ZONE0_FAULT_PIN_A_OE_O),
    .ZONE0_FAULT_PIN_B_OE_O(ZONE0_FAULT_PIN_B_OE_O),
    .ZONE1_FAULT_PIN_A_OE_O(ZONE1_FAULT_PIN_A_OE_O),
    .ZONE1_FAULT_PIN_B_OE_O(ZONE1_FAULT_PIN_B_OE_O), .PWRGD_O(PWRGD_O));

// *** tb/fault_pin_peer.sv ***
/* other managers on the four wired zone fault pins.
   assumes a pull-up on each pin; order is z1b z1a z0b z0a */
`timescale 1ns/100ps
module fault_pin_peer (
    // enables of this device and pulls of the peers
    input  wire logic [3:0] oe_i,
    input  wire logic [3:0] pull_i,
    // resolved wire level
    output logic      [3:0] pin_o
);
    // any party pulling low wins, released pins float up
    assign pin_o = ~(oe_i | pull_i);
endmodule : fault_pin_peer

// *** tb/fault_zone_pwrgd_tb.sv ***
/* self-checking bench for fault_zone_pwrgd: settings, propagation,
   power-good mapping and pin response. assumes the peer model */
`timescale 1ns/100ps
module fault_zone_pwrgd_tb;
    import fault_zone_pkg::*;
    logic         clk = 1'h0;
    logic         rst = 1'h1;
    logic         wr_s = 1'h0;
    logic         rd_s = 1'h0;
    setting_sel_t sel = SEL_NONE;
    logic [2:0]   page = 3'h0;
    logic [15:0]  wdata = 16'h0000;
    logic [15:0]  rdata;
    logic         rvalid;
    logic [7:0]   flt = 8'h00;
    logic [7:0]   pg = 8'hFF;
    logic [7:0]   hires = 8'h00;
    logic [7:0]   sd;
    logic         wdog = 1'h1;
    logic         pwrgd;
    logic [3:0]   oe;
    logic [3:0]   pin;
    logic [3:0]   pull = 4'h0;
    logic [3:0]   e;
    int           fail_count = 0;
    int           checks_done = 0;
    int           cyc = 0;

    always #10 clk = ~clk;

    fault_zone_pwrgd i_fault_zone_pwrgd (
        .CLOCK_I(clk), .RST_I(rst), .CMD_WRITE_I(wr_s), .CMD_READ_I(rd_s),
        .CMD_SEL_I(sel), .CMD_PAGE_I(page), .CMD_WDATA_I(wdata),
        .CMD_RDATA_O(rdata), .CMD_RVALID_O(rvalid),
        .CHAN_FAULTED_OFF_I(flt), .CHAN_PWRGD_I(pg), .CHAN_HIRES_I(hires),
        .WDOG_NOT_EXPIRED_I(wdog), .CHAN_SHUTDOWN_O(sd),
        .ZONE0_FAULT_PIN_A_I(pin[0]), .ZONE0_FAULT_PIN_A_O(),
        .ZONE0_FAULT_PIN_A_OE_O(oe[0]), .ZONE0_FAULT_PIN_B_I(pin[1]),
        .ZONE0_FAULT_PIN_B_O(), .ZONE0_FAULT_PIN_B_OE_O(oe[1]),
        .ZONE1_FAULT_PIN_A_I(pin[2]), .ZONE1_FAULT_PIN_A_O(),
        .ZONE1_FAULT_PIN_A_OE_O(oe[2]), .ZONE1_FAULT_PIN_B_I(pin[3]),
        .ZONE1_FAULT_PIN_B_O(), .ZONE1_FAULT_PIN_B_OE_O(oe[3]),
        .PWRGD_O(pwrgd));

    fault_pin_peer i_fault_pin_peer (.oe_i(oe), .pull_i(pull), .pin_o(pin));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input setting_sel_t s, input int p,
                      input logic [15:0] d);
        @(posedge clk);
        wr_s <= 1'h1;
        sel <= s;
        page <= p[2:0];
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'h0;
    endtask : wr

    task automatic rd(input setting_sel_t s, input int p,
                      input logic [15:0] exp);
        @(posedge clk);
        rd_s <= 1'h1;
        sel <= s;
        page <= p[2:0];
        @(posedge clk);
        rd_s <= 1'h0;
        #1;
        chk(16'(rvalid), 16'h0001);
        chk(rdata, exp);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // hang guard, about two and a half times the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            rd(SEL_PROP_A, i, 16'h0000);
            rd(SEL_PROP_B, i, 16'h0000);
        end
        rd(SEL_PG_EN, 0, 16'h0000);
        wr(SEL_PROP_A, 2, 16'hFFFF);
        rd(SEL_PROP_A, 2, 16'h0001);
        wr(SEL_PROP_B, 5, 16'hFFFE);
        rd(SEL_PROP_B, 5, 16'h0000);
        wr(SEL_PG_EN, 0, 16'hFFFF);
        rd(SEL_PG_EN, 0, 16'h01FF);
        wr(SEL_NONE, 0, 16'hFFFF);
        rd(SEL_NONE, 0, 16'h0000);
        wr(SEL_PROP_A, 2, 16'h0000);
        $display("test settings done");
        for (int c = 0; c < 8; c++) begin
            for (int b = 0; b < 2; b++) begin
                wr(b ? SEL_PROP_B : SEL_PROP_A, c, 16'h0001);
                flt <= 8'h01 << c;
                tick(2);
                e = 4'h1 << (c / 4 * 2 + b);
                chk(16'(oe), 16'(e));
                chk(16'(pin), {12'h000, ~e});
                wr(b ? SEL_PROP_B : SEL_PROP_A, c, 16'h0000);
                tick(2);
                chk(16'(oe), 16'h0000);
                flt <= 8'h00;
            end
        end
        $display("test propagation done");
        for (int i = 0; i < 9; i++) begin
            wr(SEL_PG_EN, 0, 16'h0001 << i);
            hires <= 8'h00;
            pg <= ~(8'h01 << i);
            wdog <= (i != 8);
            tick(2);
            chk(16'(pwrgd), 16'h0000);
            wr(SEL_PG_EN, 0, 16'h01FF ^ (16'h0001 << i));
            tick(2);
            chk(16'(pwrgd), 16'h0001);
            wr(SEL_PG_EN, 0, 16'h0001 << i);
            hires <= 8'hFF;
            tick(2);
            chk(16'(pwrgd), 16'(i % 2 == 1 && i < 8));
        end
        wr(SEL_PG_EN, 0, 16'h0000);
        hires <= 8'h00;
        pg <= 8'hFF;
        wdog <= 1'h1;
        $display("test power good done");
        for (int k = 0; k < 4; k++) begin
            wr(setting_sel_t'(k + 3), 0, 16'h0001 << k);
            pull <= 4'h1 << k;
            tick(400);
            chk(16'(sd), 16'h0000);
            tick(110);
            chk(16'(sd), 16'h0001 << (k / 2 * 4 + k));
            @(posedge clk);
            pull <= 4'h0;
            tick(4);
            chk(16'(sd), 16'h0000);
            wr(setting_sel_t'(k + 3), 0, 16'h0000);
        end
        $display("test pin response done");
        final_report();
    end
endmodule : fault_zone_pwrgd_tb
